// ==== hdl/scsm_consts.vh ====
/*
 * constants for the clock-stop serial port: mode codes, direction codes,
 * slave rate setting and reset values.
 * assumes it is included by bare name from the port module.
 */
`ifndef SCSM_CONSTS_VH
`define SCSM_CONSTS_VH

// ---------------------------------------------------------------
// clock-stop mode codes
// ---------------------------------------------------------------
`define SCSM_STOP_NODELAY 2'h2
`define SCSM_STOP_HALFDLY 2'h3

// ---------------------------------------------------------------
// direction codes and slave rate setting
// ---------------------------------------------------------------
`define SCSM_DIR_OUT 1'h1
`define SCSM_DIR_IN 1'h0
`define SCSM_SRC_CPU 1'h1
`define SCSM_SLAVE_DIV 8'h01

// ---------------------------------------------------------------
// master sequencer states
// ---------------------------------------------------------------
`define SCSM_ST_IDLE 2'h0
`define SCSM_ST_LEAD 2'h1
`define SCSM_ST_BITS 2'h2
`define SCSM_ST_TRAIL 2'h3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SCSM_RST_WORD 32'h0000_0000
`define SCSM_RST_BIT 1'h0

`endif

// ==== hdl/scsm_port.v ====
/*
 * clock-stop (spi style) serial port, master or slave, one clock domain.
 * assumes: clk is the cpu clock, pins are resolved from the _o/_oe/_i
 * triples outside, configuration is held steady while a word moves.
 */
`timescale 1ns/1ps
`include "scsm_consts.vh"

module scsm_port
#(
   parameter WORD = 8
)
(
   input wire clk,
   input wire rst_b,
   input wire master_mode,
   input wire [1:0] clock_stop_mode,
   input wire tx_clock_polarity,
   input wire tx_frame_polarity,
   input wire rx_frame_polarity,
   input wire [7:0] rate_divide_value,
   input wire [WORD-1:0] tx_data,
   input wire tx_valid,
   output reg tx_ready_q,
   output reg [WORD-1:0] rx_data_q,
   output reg rx_valid_q,
   output reg tx_clock_direction_q,
   output reg rx_clock_direction_q,
   output reg tx_frame_direction_q,
   output reg rx_frame_direction_q,
   output reg rate_clock_source_q,
   output reg sample_rate_clock_q,
   input wire tx_bit_clock_i,
   output reg tx_bit_clock_o_q,
   output reg tx_bit_clock_oe_q,
   input wire tx_frame_select_i,
   output reg tx_frame_select_o_q,
   output reg tx_frame_select_oe_q,
   input wire rx_frame_select_i,
   input wire rx_serial_in,
   output reg tx_serial_out_q,
   output reg tx_serial_out_oe_q
);

   localparam CW = 8;
   localparam BW = 6;
   localparam integer EDGE_CNT = 2 * WORD - 1;
   localparam integer BIT_CNT = WORD;
   localparam [BW-1:0] EDGES = EDGE_CNT[BW-1:0];
   localparam [BW-1:0] NBITS = BIT_CNT[BW-1:0];

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   reg [2:0] sclk_q;
   reg [1:0] sfx_q;
   reg [1:0] sfr_q;
   reg [1:0] sdin_q;

   // two stages before any logic, third stage only for edge finding
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         sclk_q <= 3'h0;
         sfx_q <= 2'h3;
         sfr_q <= 2'h3;
         sdin_q <= 2'h0;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], tx_bit_clock_i};
         sfx_q <= {sfx_q[0], tx_frame_select_i};
         sfr_q <= {sfr_q[0], rx_frame_select_i};
         sdin_q <= {sdin_q[0], rx_serial_in};
      end
   end

   // ---------------------------------------------------------------
   // phase lengths
   // ---------------------------------------------------------------
   reg [CW-1:0] div;
   reg [CW-1:0] len_lo;
   reg [CW-1:0] len_hi;
   wire mode11 = (clock_stop_mode == `SCSM_STOP_HALFDLY);
   // capture edge per variant, launch on the other edge
   wire cap_rise = (mode11 & ~tx_clock_polarity) | (~mode11 & tx_clock_polarity);
   wire idle_lvl = tx_clock_polarity;

   // half time units fold into whole cycles; zero divide is clamped
   always @*
   begin
      div = master_mode ? rate_divide_value : `SCSM_SLAVE_DIV;
      if (div == 8'h00)
         div = 8'h01;
      if (div[0])
      begin
         len_lo = (div >> 1) + 8'h01;
         len_hi = (div >> 1) + 8'h01;
      end
      else
      begin
         len_lo = div >> 1;
         len_hi = (div >> 1) + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // directions and free-running sample-rate clock
   // ---------------------------------------------------------------
   reg [CW-1:0] rpc_q;

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         tx_clock_direction_q <= `SCSM_DIR_IN;
         rx_clock_direction_q <= `SCSM_DIR_IN;
         tx_frame_direction_q <= `SCSM_DIR_IN;
         rx_frame_direction_q <= `SCSM_DIR_IN;
         rate_clock_source_q <= `SCSM_SRC_CPU;
         sample_rate_clock_q <= 1'h0;
         rpc_q <= 8'h00;
      end
      else
      begin
         tx_clock_direction_q <= master_mode ? `SCSM_DIR_OUT : `SCSM_DIR_IN;
         tx_frame_direction_q <= master_mode ? `SCSM_DIR_OUT : `SCSM_DIR_IN;
         rx_clock_direction_q <= `SCSM_DIR_IN;
         rx_frame_direction_q <= `SCSM_DIR_IN;
         rate_clock_source_q <= `SCSM_SRC_CPU;
         if (rpc_q == 8'h00)
         begin
            sample_rate_clock_q <= ~sample_rate_clock_q;
            rpc_q <= (sample_rate_clock_q ? len_lo : len_hi) - 8'h01;
         end
         else
            rpc_q <= rpc_q - 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // master sequencer
   // ---------------------------------------------------------------
   reg [1:0] st_q;
   reg [CW-1:0] pc_q;
   reg [BW-1:0] hp_q;
   wire m_start = master_mode & (st_q == `SCSM_ST_IDLE) & tx_valid;
   wire ph_end = (pc_q == 8'h00);
   wire m_edge = ph_end & (((st_q == `SCSM_ST_LEAD) & (hp_q == 6'h01)) |
                 ((st_q == `SCSM_ST_BITS) & (hp_q != 6'h00)));
   wire m_rise = ~tx_bit_clock_o_q;
   wire [CW-1:0] len_idle = idle_lvl ? len_hi : len_lo;
   wire [CW-1:0] len_next = m_rise ? len_hi : len_lo;

   // select leads first edge by one phase (10b) or a full period (11b)
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         st_q <= `SCSM_ST_IDLE;
         pc_q <= 8'h00;
         hp_q <= 6'h00;
         tx_bit_clock_o_q <= `SCSM_RST_BIT;
         tx_bit_clock_oe_q <= `SCSM_DIR_IN;
         tx_frame_select_o_q <= 1'h1;
         tx_frame_select_oe_q <= `SCSM_DIR_IN;
         tx_ready_q <= 1'h0;
      end
      else
      begin
         tx_bit_clock_oe_q <= master_mode;
         tx_frame_select_oe_q <= master_mode;
         case (st_q)
            `SCSM_ST_IDLE:
            begin
               tx_bit_clock_o_q <= idle_lvl;
               tx_frame_select_o_q <= tx_frame_polarity;
               tx_ready_q <= master_mode & ~tx_valid;
               if (m_start)
               begin
                  tx_frame_select_o_q <= ~tx_frame_polarity;
                  pc_q <= len_idle - 8'h01;
                  hp_q <= mode11 ? 6'h02 : 6'h01;
                  st_q <= `SCSM_ST_LEAD;
               end
            end
            `SCSM_ST_LEAD:
            begin
               if (!ph_end)
                  pc_q <= pc_q - 8'h01;
               else if (hp_q == 6'h01)
               begin
                  tx_bit_clock_o_q <= m_rise;
                  pc_q <= len_next - 8'h01;
                  hp_q <= EDGES;
                  st_q <= `SCSM_ST_BITS;
               end
               else
               begin
                  pc_q <= len_next - 8'h01;
                  hp_q <= hp_q - 6'h01;
               end
            end
            `SCSM_ST_BITS:
            begin
               if (!ph_end)
                  pc_q <= pc_q - 8'h01;
               else if (hp_q != 6'h00)
               begin
                  tx_bit_clock_o_q <= m_rise;
                  pc_q <= len_next - 8'h01;
                  hp_q <= hp_q - 6'h01;
               end
               else
               begin
                  pc_q <= len_idle - 8'h01;
                  st_q <= `SCSM_ST_TRAIL;
               end
            end
            `SCSM_ST_TRAIL:
            begin
               if (!ph_end)
                  pc_q <= pc_q - 8'h01;
               else
               begin
                  tx_frame_select_o_q <= tx_frame_polarity;
                  st_q <= `SCSM_ST_IDLE;
               end
            end
            default:
               st_q <= `SCSM_ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // slave framing and edge finding
   // ---------------------------------------------------------------
   reg s_act_q;
   wire s_tx_act = sfx_q[1] ^ tx_frame_polarity;
   wire s_rx_act = sfr_q[1] ^ rx_frame_polarity;
   wire s_start = ~master_mode & s_tx_act & ~s_act_q;
   wire s_edge = ~master_mode & (sclk_q[2] ^ sclk_q[1]);

   always @(posedge clk)
   begin
      if (!rst_b)
         s_act_q <= 1'h0;
      else
         s_act_q <= ~master_mode & s_tx_act;
   end

   // ---------------------------------------------------------------
   // shared shift path
   // ---------------------------------------------------------------
   reg [WORD-1:0] tsh_q;
   reg [WORD-1:0] rsh_q;
   reg [BW-1:0] bits_q;
   wire start = m_start | s_start;
   wire edge_now = m_edge | (s_edge & (s_tx_act | s_rx_act));
   wire rise = master_mode ? m_rise : sclk_q[1];
   wire frame_on = master_mode ? (st_q != `SCSM_ST_IDLE) : s_tx_act;
   wire [BW-1:0] bits_inc = bits_q + 6'h01;

   // capture on one edge, launch on the other once a bit is in
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         tsh_q <= {WORD{`SCSM_RST_BIT}};
         rsh_q <= {WORD{`SCSM_RST_BIT}};
         bits_q <= 6'h00;
         rx_data_q <= {WORD{`SCSM_RST_BIT}};
         rx_valid_q <= 1'h0;
         tx_serial_out_q <= `SCSM_RST_BIT;
         tx_serial_out_oe_q <= 1'h0;
      end
      else
      begin
         rx_valid_q <= 1'h0;
         if (start)
         begin
            tsh_q <= tx_data << 1;
            tx_serial_out_q <= tx_data[WORD-1];
            tx_serial_out_oe_q <= 1'h1;
            bits_q <= 6'h00;
         end
         else if (!frame_on & !m_start)
            tx_serial_out_oe_q <= 1'h0;
         else if (edge_now)
         begin
            if (rise == cap_rise)
            begin
               rsh_q <= {rsh_q[WORD-2:0], sdin_q[1]};
               if (bits_inc == NBITS)
               begin
                  rx_data_q <= {rsh_q[WORD-2:0], sdin_q[1]};
                  rx_valid_q <= 1'h1;
                  bits_q <= 6'h00;
               end
               else
                  bits_q <= bits_inc;
            end
            else if (bits_q != 6'h00)
            begin
               tx_serial_out_q <= tsh_q[WORD-1];
               tsh_q <= tsh_q << 1;
            end
         end
      end
   end

endmodule

// ==== bench/scsm_port_chk.sv ====
/* assertions on the pins of the clock-stop serial port.
   assumes a bind onto scsm_port, one clock clk, frame polarity one in master. */
`timescale 1ns/1ps
module scsm_port_chk
#(
   parameter WORD = 8
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic master_mode,
   input wire logic [1:0] clock_stop_mode,
   input wire logic tx_clock_polarity,
   input wire logic tx_frame_polarity,
   input wire logic [7:0] rate_divide_value,
   input wire logic [WORD-1:0] tx_data,
   input wire logic tx_clock_direction_q,
   input wire logic rx_clock_direction_q,
   input wire logic tx_frame_direction_q,
   input wire logic rx_frame_direction_q,
   input wire logic rate_clock_source_q,
   input wire logic sample_rate_clock_q,
   input wire logic tx_bit_clock_o_q,
   input wire logic tx_frame_select_o_q,
   input wire logic tx_frame_select_i,
   input wire logic tx_serial_out_q,
   input wire logic tx_serial_out_oe_q
);
   logic prev_q;
   logic [8:0] cnt_q;
   logic [8:0] scnt_q;
   logic [5:0] edg_q;
   wire [8:0] dv = (rate_divide_value == 8'h00) ? 9'h001 : {1'b0, rate_divide_value};
   wire [8:0] lo = dv[0] ? (dv + 9'h001) >> 1 : dv >> 1;
   wire [8:0] hi = dv[0] ? lo : lo + 9'h001;
   wire act = master_mode && tx_frame_polarity && !tx_frame_select_o_q;
   wire chg = tx_bit_clock_o_q != prev_q;
   wire cap = (clock_stop_mode == 2'h3) ^ tx_clock_polarity;
   wire [3:0] dirs = {tx_clock_direction_q, tx_frame_direction_q, rx_clock_direction_q,
      rx_frame_direction_q};
   // phase, lead and edge counters of the master bit clock
   always @(posedge clk)
   begin
      prev_q <= tx_bit_clock_o_q;
      cnt_q <= chg ? 9'h001 : cnt_q + 9'h001;
      scnt_q <= act ? scnt_q + 9'h001 : 9'h000;
      edg_q <= act ? edg_q + {5'h00, chg} : 6'h00;
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   a_dir_master: assert property (
      $past(rst_b) && $past(master_mode) |-> dirs == 4'hc) else $error("bad master dirs");
   a_dir_slave: assert property (
      $past(rst_b) && !$past(master_mode) |-> dirs == 4'h0 && rate_clock_source_q)
      else $error("bad slave dirs");
   a_rate_half: assert property (
      (rst_b && !master_mode) [*3] |-> sample_rate_clock_q != $past(sample_rate_clock_q))
      else $error("slave rate clock not half");
   a_phase_low: assert property (
      act && chg && edg_q != 6'h00 && tx_bit_clock_o_q |-> cnt_q == lo)
      else $error("low phase length");
   a_phase_high: assert property (
      act && chg && edg_q != 6'h00 && !tx_bit_clock_o_q |-> cnt_q == hi)
      else $error("high phase length");
   a_lead_time: assert property (
      act && chg && edg_q == 6'h00 |->
      scnt_q == ((clock_stop_mode == 2'h3) ? dv + 9'h001 : (tx_clock_polarity ? hi : lo)))
      else $error("select lead length");
   a_cap_stable: assert property (
      act && chg && tx_bit_clock_o_q == cap |-> $stable(tx_serial_out_q))
      else $error("data moved at capture");
   a_first_bit: assert property (
      !master_mode && $fell(tx_frame_select_i) |->
      ##[1:4] (tx_serial_out_oe_q && tx_serial_out_q == tx_data[WORD-1]))
      else $error("slave first bit late");
   a_slave_float: assert property (
      (!master_mode && tx_frame_select_i) [*5] |-> !tx_serial_out_oe_q)
      else $error("slave data not released");
   a_master_float: assert property (
      master_mode && tx_frame_select_o_q && $past(tx_frame_select_o_q) |-> !tx_serial_out_oe_q)
      else $error("master data not released");
   c_master_edge: cover property (act && chg);
   c_half_pol1: cover property (act && chg && clock_stop_mode == 2'h3 && tx_clock_polarity);
   c_slave_drive: cover property (!master_mode && tx_serial_out_oe_q);
endmodule
bind scsm_port scsm_port_chk #(.WORD(WORD)) u_chk (.clk(clk), .rst_b(rst_b),
   .master_mode(master_mode), .clock_stop_mode(clock_stop_mode),
   .tx_clock_polarity(tx_clock_polarity), .tx_frame_polarity(tx_frame_polarity),
   .rate_divide_value(rate_divide_value), .tx_data(tx_data),
   .tx_clock_direction_q(tx_clock_direction_q), .rx_clock_direction_q(rx_clock_direction_q),
   .tx_frame_direction_q(tx_frame_direction_q), .rx_frame_direction_q(rx_frame_direction_q),
   .rate_clock_source_q(rate_clock_source_q), .sample_rate_clock_q(sample_rate_clock_q),
   .tx_bit_clock_o_q(tx_bit_clock_o_q), .tx_frame_select_o_q(tx_frame_select_o_q),
   .tx_frame_select_i(tx_frame_select_i), .tx_serial_out_q(tx_serial_out_q),
   .tx_serial_out_oe_q(tx_serial_out_oe_q));

// ==== bench/scsm_partner.sv ====
/* behavioural spi slave beside the port in master mode.
   assumes the bench gives the capture level and the select is active low. */
`timescale 1ns/1ps
module scsm_partner
(
   input wire logic sclk,
   input wire logic sel_b,
   input wire logic cap_lvl,
   input wire logic mosi,
   input wire logic [7:0] load_word,
   output logic miso,
   output logic [7:0] got
);
   logic [7:0] sr = 8'h00;
   logic last = 1'b0;
   // reply word loaded as the select opens the frame
   always @(negedge sel_b)
      sr = load_word;
   // shift both ways on the capture edge only
   always @(sclk)
      if (sel_b === 1'b0 && sclk === cap_lvl)
      begin
         last = sr[7];
         sr = {sr[6:0], mosi};
      end
   // released line shows the inverse of its last bit
   assign miso = sel_b ? ~last : sr[7];
   assign got = sr;
endmodule

// ==== bench/serial_port_spi_clock_stop_mode_tb.sv ====
/* self-checking bench for the clock-stop serial port.
   assumes scsm_port with its bound checker and the scsm_partner model. */
`timescale 1ns/1ps
module serial_port_spi_clock_stop_mode_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic mm = 1'b1;
   logic [1:0] md = 2'h2;
   logic pl = 1'b0;
   logic [7:0] dv = 8'h03;
   logic [7:0] td = 8'h00;
   logic tv = 1'b0;
   logic sck = 1'b0;
   logic sel = 1'b1;
   logic din = 1'b0;
   logic [7:0] pw = 8'h00;
   logic [31:0] seed = 32'h0ff54eee;
   int err_total = 0;
   int cmp_count = 0;
   wire rdy, rxv, src, bco, bcoe, fso, fsoe, dq, dqoe, miso;
   wire [3:0] dirs;
   wire [7:0] rxd;
   wire [7:0] got;
   wire bclk = bcoe ? bco : sck;
   wire fsel = fsoe ? fso : sel;
   wire cap = (md == 2'h3) ^ pl;
   // 10 MHz cpu clock
   always #50 clk = ~clk;
   scsm_port i_dut (.clk(clk), .rst_b(rst_b), .master_mode(mm), .clock_stop_mode(md),
      .tx_clock_polarity(pl), .tx_frame_polarity(1'b1), .rx_frame_polarity(1'b1),
      .rate_divide_value(dv), .tx_data(td), .tx_valid(tv), .tx_ready_q(rdy), .rx_data_q(rxd),
      .rx_valid_q(rxv), .tx_clock_direction_q(dirs[3]), .rx_clock_direction_q(dirs[1]),
      .tx_frame_direction_q(dirs[2]), .rx_frame_direction_q(dirs[0]),
      .rate_clock_source_q(src), .sample_rate_clock_q(), .tx_bit_clock_i(bclk),
      .tx_bit_clock_o_q(bco), .tx_bit_clock_oe_q(bcoe), .tx_frame_select_i(fsel),
      .tx_frame_select_o_q(fso), .tx_frame_select_oe_q(fsoe), .rx_frame_select_i(sel),
      .rx_serial_in(mm ? miso : din), .tx_serial_out_q(dq), .tx_serial_out_oe_q(dqoe));
   scsm_partner i_far (.sclk(bclk), .sel_b(fsel), .cap_lvl(cap), .mosi(dq), .load_word(pw),
      .miso(miso), .got(got));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [3:0] dexp(input logic m);
      return m ? 4'hc : 4'h0;
   endfunction
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_total++;
         $display("wrong value at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // one master word, request held until the port goes busy
   task automatic mframe(input logic [1:0] m, input logic p, input logic [7:0] d);
      logic [7:0] w;
      w = rnd();
      md <= m;
      pl <= p;
      dv <= d;
      td <= w;
      pw <= rnd();
      @(posedge clk);
      tv <= 1'b1;
      repeat (300) if (rdy !== 1'b0) @(posedge clk);
      tv <= 1'b0;
      repeat (300) if (rxv !== 1'b1) @(posedge clk);
      chk(rxd, pw);
      repeat (300) if (rdy !== 1'b1) @(posedge clk);
      chk(got, w);
      chk({4'h0, dirs}, {4'h0, dexp(1'b1)});
      $display("master word done mode %h pol %h div %h", m, p, d);
   endtask
   // one slave word clocked by the bench at 16 cycles per bit
   task automatic sframe(input logic [1:0] m, input logic p);
      logic [7:0] w;
      logic [7:0] wi;
      logic [7:0] seen;
      int n;
      w = rnd();
      wi = rnd();
      md <= m;
      pl <= p;
      sck <= p;
      td <= w;
      repeat (4) @(posedge clk);
      sel <= 1'b0;
      din <= wi[7];
      repeat (5) @(posedge clk);
      chk({6'h00, dqoe, dq}, {6'h00, 1'b1, w[7]});
      n = 0;
      for (int t = 0; t < 16; t++)
      begin
         repeat (4) @(posedge clk);
         if (n < 8)
            din <= wi[7 - n];
         repeat (4) @(posedge clk);
         if (!sck == cap)
         begin
            seen[7 - n] = dq;
            n++;
         end
         sck <= !sck;
      end
      repeat (6) @(posedge clk);
      chk(rxd, wi);
      chk(seen, w);
      sel <= 1'b1;
      repeat (6) @(posedge clk);
      chk({7'h00, dqoe}, 8'h00);
      chk({3'h0, dirs, src}, {3'h0, dexp(1'b0), 1'b1});
      $display("slave word done mode %h pol %h", m, p);
   endtask
   // main sequence: master variants, second reset, slave variants
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 12; i++)
         mframe(i[1] ? 2'h3 : 2'h2, i[0], (i < 4) ? 8'h03 : (i < 8) ? 8'h04 : 8'(3 + rnd() % 6));
      rst_b <= 1'b0;
      mm <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++)
         sframe(i[1] ? 2'h3 : 2'h2, i[0]);
      test_done;
   end
   // watchdog well beyond the few thousand cycles the words need
   initial
   begin
      repeat (40000) @(posedge clk);
      err_total++;
      test_done;
   end
endmodule
